//--- lpm_pkg.sv
// Purpose: shared constants and types for the low power mode controller
// Assumes: apb register bus, 32-bit data, one clock
// Notes: offsets are byte addresses of aligned words
package lpm_pkg;

   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] power_control_reg_three_off = 8'h04;
   localparam logic [7:0] io_pull_up_off = 8'h08;
   localparam logic [7:0] io_pull_dn_off = 8'h0c;
   localparam logic [7:0] status_off = 8'h10;
   localparam logic [7:0] wake_off = 8'h14;

   // ctrl fields
   localparam int mode_lsb = 0;
   localparam int mode_w = 3;
   localparam int stop_clk_hsi_bit = 4;
   localparam int flash_pd_bit = 5;
   localparam int sram_gate_bit = 6;
   // power_control_reg_three fields
   localparam int sram_retain_select_bit = 0;
   localparam int wake_en_lsb = 1;
   localparam int wake_pol_lsb = 6;

   localparam int wake_pins = 5;
   localparam int io_count = 16;

   localparam logic [31:0] ctrl_rst = 32'h0000_0000;
   localparam logic [31:0] cr3_rst = 32'h0000_0000;

   localparam logic [1:0] clk_msi = 2'h0;
   localparam logic [1:0] clk_hsi = 2'h1;
   localparam logic [1:0] clk_msi_low = 2'h2;

   localparam logic [2:0] sel_run = 3'h0;
   localparam logic [2:0] sel_sleep = 3'h1;
   localparam logic [2:0] sel_lprun = 3'h2;
   localparam logic [2:0] sel_stop0 = 3'h3;
   localparam logic [2:0] sel_stop1 = 3'h4;
   localparam logic [2:0] sel_stop2 = 3'h5;
   localparam logic [2:0] sel_standby = 3'h6;
   localparam logic [2:0] sel_shutdown = 3'h7;

   typedef enum logic [3:0] {
      st_run, st_sleep, st_lprun, st_lpsleep, st_stop0, st_stop1, st_stop2,
      st_standby, st_shutdown
   } pmode_type;

   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic main_reg_on;
      logic lp_reg_on;
      logic core_low_leak;
      logic core_power_on;
      logic pll_en;
      logic msi_en;
      logic hsi_en;
      logic hse_en;
      logic brownout_en;
      logic retain_sram;
      logic main_sram_keep;
      logic flash_pd;
      logic sram_clk_en;
      logic lp_cpu_cap;
   } power_ctl_type;

   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_type;

endpackage

//--- low_power_mode_controller.sv
// Purpose: power mode sequencing, wakeup collection and reset i/o state
// Assumes: wakeup sources and core sleep signals synchronous to core_clk
// Notes: apb answers in the access cycle, zero wait states
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - run mode after any reset
// - sleep stops cpu only, interrupt wakes
// - low power run: lp regulator, 2 mhz cap
// - lp sleep only from lp run, returns
// - stop halts core clocks, fast oscillators off
// - three stop levels, regulator and leakage
// - stop exit clock msi or hsi by software
// - hsi on stop request feeds requester only
// - standby: regulator off, brownout stays on
// - standby loses contents, optional sram retention
// - standby exit on listed reset/wake sources
// - standby wake clock is msi low range
// - standby holds software pull configuration
// - shutdown pull configuration dropped on exit
// - five dedicated wake pins only
// - reset leaves i/o analog, schmitt off
// - internal reset drops reset pin pullup
// - backup domain to battery without main supply
// - battery mode not ended by interrupts
// - flash power down selectable, sram gate
module low_power_mode_controller #(
   parameter int io_n = lpm_pkg::io_count
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire lpm_pkg::apb_req_type apb_req,
   output lpm_pkg::apb_rsp_type apb_rsp,
   input wire logic cpu_wait,
   input wire logic periph_irq,
   input wire logic [3:0] hsi_request,
   input wire logic external_reset_pin,
   input wire logic independent_watchdog,
   input wire logic [lpm_pkg::wake_pins-1:0] wakeup_pin,
   input wire logic rtc_event,
   input wire logic low_speed_crystal_fail,
   input wire logic internal_reset,
   input wire logic main_supply_ok,
   output lpm_pkg::power_ctl_type power_ctl,
   output logic [1:0] sys_clk_sel,
   output logic [3:0] hsi_grant,
   output logic low_speed_osc_en,
   output logic cpu_wake,
   output logic [io_n-1:0] io_pull_up,
   output logic [io_n-1:0] io_pull_dn,
   output logic io_analog,
   output logic io_schmitt_en,
   output logic reset_pin_pullup_en,
   output logic battery_select,
   output logic [3:0] mode_code
);
   import lpm_pkg::*;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [31:0] cr3_reg;
   logic [31:0] pull_up_reg;
   logic [31:0] pull_dn_reg;
   logic [wake_pins-1:0] wake_flag_reg;
   pmode_type mode_reg, mode_next;
   logic pending_reg;
   logic wake_latch_reg;
   logic [wake_pins-1:0] pin_last_reg;
   logic shutdown_exit_reg;

   logic wr_en;
   logic rd_en;
   logic mapped;
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   assign mapped = apb_req.paddr[7:0] == ctrl_off ||
      apb_req.paddr[7:0] == power_control_reg_three_off ||
      apb_req.paddr[7:0] == io_pull_up_off ||
      apb_req.paddr[7:0] == io_pull_dn_off ||
      apb_req.paddr[7:0] == status_off ||
      apb_req.paddr[7:0] == wake_off;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= ctrl_rst;
         cr3_reg <= cr3_rst;
         pull_up_reg <= '0;
         pull_dn_reg <= '0;
      end else if (wr_en && apb_req.paddr[31:8] == '0) begin
         unique case (apb_req.paddr[7:0])
            ctrl_off: ctrl_reg <= apb_req.pwdata;
            power_control_reg_three_off: cr3_reg <= apb_req.pwdata;
            io_pull_up_off: pull_up_reg <= apb_req.pwdata;
            io_pull_dn_off: pull_dn_reg <= apb_req.pwdata;
            default: ;
         endcase
      end else if (shutdown_exit_reg) begin
         pull_up_reg <= '0;
         pull_dn_reg <= '0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= apb_req.psel & ~apb_req.penable;
         apb_rsp.pslverr <= apb_req.psel & ~apb_req.penable &
            ~(mapped && apb_req.paddr[31:8] == '0);
         apb_rsp.prdata <= '0;
         if (apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
            apb_req.paddr[31:8] == '0) begin
            unique case (apb_req.paddr[7:0])
               ctrl_off: apb_rsp.prdata <= ctrl_reg;
               power_control_reg_three_off: apb_rsp.prdata <= cr3_reg;
               io_pull_up_off: apb_rsp.prdata <= pull_up_reg;
               io_pull_dn_off: apb_rsp.prdata <= pull_dn_reg;
               status_off: apb_rsp.prdata <=
                  {27'h0, battery_select, mode_reg};
               wake_off: apb_rsp.prdata <= {27'h0, wake_flag_reg};
               default: apb_rsp.prdata <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // wakeup collection
   // ----------------------------------------------------------------
   logic [wake_pins-1:0] pin_edge;
   logic [wake_pins-1:0] pin_en;
   logic [wake_pins-1:0] pin_pol;
   logic pins_armed_reg;
   logic deep_wake;
   logic any_wake;
   logic wake_clear;
   assign pin_en = cr3_reg[wake_en_lsb +: wake_pins];
   assign pin_pol = cr3_reg[wake_pol_lsb +: wake_pins];
   assign wake_clear = wr_en && apb_req.paddr == {24'h0, wake_off};

   genvar gi;
   generate
      for (gi = 0; gi < wake_pins; gi++) begin : g_pin
         // pol 0 rising, pol 1 falling
         assign pin_edge[gi] = pins_armed_reg & pin_en[gi] & (pin_pol[gi] ?
            (pin_last_reg[gi] & ~wakeup_pin[gi]) :
            (~pin_last_reg[gi] & wakeup_pin[gi]));
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_last_reg <= '0;
      end else begin
         pin_last_reg <= wakeup_pin;
      end
   end

   // reset value of pin_last is not the pin level: no edge on cycle one
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pins_armed_reg <= 1'b0;
      end else begin
         pins_armed_reg <= 1'b1;
      end
   end

   // set wins over software clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wake_flag_reg <= '0;
      end else begin
         wake_flag_reg <= (wake_clear ? wake_flag_reg &
            ~apb_req.pwdata[wake_pins-1:0] : wake_flag_reg) | pin_edge;
      end
   end

   // the five pins, reset pin, watchdog, rtc and crystal fail reach standby and shutdown
   assign deep_wake = |pin_edge | external_reset_pin | independent_watchdog |
      rtc_event | low_speed_crystal_fail;
   assign any_wake = periph_irq | deep_wake;

   // ----------------------------------------------------------------
   // mode sequencing
   // ----------------------------------------------------------------
   logic [2:0] sel;
   logic is_stop;
   assign sel = ctrl_reg[mode_lsb +: mode_w];
   assign is_stop = mode_reg == st_stop0 || mode_reg == st_stop1 ||
      mode_reg == st_stop2;

   // request waits for the core wait state
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pending_reg <= 1'b0;
      end else if (wr_en && apb_req.paddr == {24'h0, ctrl_off}) begin
         pending_reg <= apb_req.pwdata[mode_lsb +: mode_w] != sel_run &&
            apb_req.pwdata[mode_lsb +: mode_w] != sel_lprun;
      end else if (mode_reg != mode_next) begin
         pending_reg <= pending_reg & (mode_reg == st_run ||
            mode_reg == st_lprun) & 1'b0;
      end
   end

   // wake seen while entry is due is latched, but it blocks the entry, so the mode stays
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wake_latch_reg <= 1'b0;
      end else begin
         wake_latch_reg <= any_wake & (mode_reg == st_run ||
            mode_reg == st_lprun) & cpu_wait & pending_reg;
      end
   end

   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         st_run, st_lprun: begin
            if (sel == sel_lprun && mode_reg == st_run) begin
               mode_next = st_lprun;
            end else if (sel == sel_run && mode_reg == st_lprun) begin
               mode_next = st_run;
            end else if (pending_reg && cpu_wait && !any_wake) begin
               unique case (sel)
                  sel_sleep: mode_next = mode_reg == st_lprun ?
                     st_lpsleep : st_sleep;
                  sel_stop0: mode_next = st_stop0;
                  sel_stop1: mode_next = st_stop1;
                  sel_stop2: mode_next = st_stop2;
                  sel_standby: mode_next = st_standby;
                  sel_shutdown: mode_next = st_shutdown;
                  default: mode_next = mode_reg;
               endcase
            end
         end
         st_sleep: if (any_wake || wake_latch_reg) mode_next = st_run;
         st_lpsleep: if (any_wake || wake_latch_reg) begin
            mode_next = st_lprun;
         end
         st_stop0, st_stop1, st_stop2: begin
            if (any_wake || wake_latch_reg) mode_next = st_run;
         end
         st_standby, st_shutdown: begin
            if (deep_wake || wake_latch_reg) mode_next = st_run;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= st_run;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shutdown_exit_reg <= 1'b0;
      end else begin
         shutdown_exit_reg <= mode_reg == st_shutdown &&
            mode_next != st_shutdown;
      end
   end

   // ----------------------------------------------------------------
   // power and clock controls
   // ----------------------------------------------------------------
   power_ctl_type pc_next;
   logic [1:0] clk_next;
   always_comb begin
      pc_next = '0;
      pc_next.brownout_en = 1'b1;
      pc_next.flash_pd = ctrl_reg[flash_pd_bit];
      pc_next.sram_clk_en = ~ctrl_reg[sram_gate_bit];
      pc_next.core_power_on = 1'b1;
      pc_next.main_sram_keep = 1'b1;
      pc_next.retain_sram = 1'b1;
      clk_next = sys_clk_sel;
      unique case (mode_next)
         st_run, st_sleep: begin
            pc_next.cpu_clk_en = mode_next == st_run;
            pc_next.core_clk_en = 1'b1;
            pc_next.main_reg_on = 1'b1;
            pc_next.pll_en = 1'b1;
            pc_next.msi_en = 1'b1;
            pc_next.hsi_en = 1'b1;
            pc_next.hse_en = 1'b1;
         end
         st_lprun, st_lpsleep: begin
            pc_next.cpu_clk_en = mode_next == st_lprun;
            pc_next.core_clk_en = 1'b1;
            pc_next.lp_reg_on = 1'b1;
            pc_next.lp_cpu_cap = 1'b1;
            pc_next.msi_en = 1'b1;
            pc_next.hsi_en = 1'b1;
         end
         st_stop0, st_stop1, st_stop2: begin
            // clocks and fast oscillators off except hsi on request, contents kept
            pc_next.main_reg_on = mode_next == st_stop0;
            pc_next.lp_reg_on = mode_next != st_stop0;
            pc_next.core_low_leak = mode_next == st_stop2;
            pc_next.hsi_en = |hsi_request;
            clk_next = ctrl_reg[stop_clk_hsi_bit] ? clk_hsi : clk_msi;
         end
         st_standby, st_shutdown: begin
            pc_next.core_power_on = 1'b0;
            pc_next.main_sram_keep = 1'b0;
            pc_next.brownout_en = mode_next == st_standby;
            pc_next.retain_sram = mode_next == st_standby &&
               cr3_reg[sram_retain_select_bit];
            pc_next.lp_reg_on = pc_next.retain_sram;
            clk_next = clk_msi_low;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         power_ctl <= '0;
         sys_clk_sel <= clk_msi;
         hsi_grant <= '0;
         low_speed_osc_en <= 1'b0;
         cpu_wake <= 1'b0;
         mode_code <= '0;
      end else begin
         power_ctl <= pc_next;
         sys_clk_sel <= clk_next;
         hsi_grant <= (mode_next == st_stop0 || mode_next == st_stop1 ||
            mode_next == st_stop2) ? hsi_request : '0;
         low_speed_osc_en <= 1'b1;
         cpu_wake <= mode_reg != st_run && mode_reg != st_lprun &&
            (mode_next == st_run || mode_next == st_lprun);
         mode_code <= 4'(mode_next);
      end
   end

   // ----------------------------------------------------------------
   // i/o and supply state
   // ----------------------------------------------------------------
   logic deep_next;
   assign deep_next = mode_next == st_standby || mode_next == st_shutdown;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         io_pull_up <= '0;
         io_pull_dn <= '0;
         io_analog <= 1'b1;
         io_schmitt_en <= 1'b0;
         reset_pin_pullup_en <= 1'b1;
         battery_select <= 1'b0;
      end else begin
         // pulls only held while in the deep modes
         io_pull_up <= deep_next ? pull_up_reg[io_n-1:0] : '0;
         io_pull_dn <= deep_next ? pull_dn_reg[io_n-1:0] : '0;
         io_analog <= 1'b1;
         io_schmitt_en <= 1'b0;
         reset_pin_pullup_en <= ~internal_reset;
         // supply alone decides, no wake source is looked at
         battery_select <= ~main_supply_ok;
      end
   end

endmodule // low_power_mode_controller
`default_nettype wire

//--- lpm_checker_sva.sv
// Purpose: port level checks for the power mode controller
// Assumes: one clock domain, rstn asynchronous active low
// Notes: bound to every controller instance below
`timescale 1ns/10ps
`default_nettype none
module lpm_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [3:0] hsi_request,
   input wire logic cpu_wait,
   input wire logic internal_reset,
   input wire logic main_supply_ok,
   input wire lpm_pkg::power_ctl_type power_ctl,
   input wire logic [3:0] hsi_grant,
   input wire logic cpu_wake,
   input wire logic io_analog,
   input wire logic io_schmitt_en,
   input wire logic reset_pin_pullup_en,
   input wire logic battery_select,
   input wire logic [3:0] mode_code
);
   import lpm_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   io_analog_a:
      assert property (io_analog && !io_schmitt_en)
      else $error("io not analog");
   pin_pullup_a:
      assert property (reset_pin_pullup_en == !$past(internal_reset))
      else $error("reset pin pullup wrong");
   battery_switch_a:
      assert property (battery_select == !$past(main_supply_ok))
      else $error("battery select wrong");
   hsi_grant_a:
      assert property ((hsi_grant & ~$past(hsi_request)) == 4'h0)
      else $error("hsi granted unasked");
   // hsi may legally run for a requester, so it is left out here
   stop_clocks_a:
      assert property (mode_code inside {st_stop0, st_stop1, st_stop2} |->
         !(power_ctl.core_clk_en | power_ctl.pll_en | power_ctl.msi_en |
           power_ctl.hse_en))
      else $error("clock alive in stop");
   stop_zero_a:
      assert property (mode_code == st_stop0 |-> power_ctl.main_reg_on)
      else $error("stop0 regulator off");
   stop_two_a:
      assert property (mode_code == st_stop2 |-> power_ctl.core_low_leak)
      else $error("stop2 leakage mode off");
   standby_power_a:
      assert property (mode_code == st_standby |-> !power_ctl.core_power_on
         && power_ctl.brownout_en && !power_ctl.pll_en && !power_ctl.msi_en)
      else $error("standby power wrong");
   sleep_clock_a:
      assert property (mode_code == st_sleep |->
         !power_ctl.cpu_clk_en && power_ctl.core_clk_en)
      else $error("sleep clocks wrong");
   lprun_supply_a:
      assert property (mode_code == st_lprun |->
         power_ctl.lp_reg_on && power_ctl.lp_cpu_cap)
      else $error("lprun supply wrong");
   entry_wait_a:
      assert property (($changed(mode_code) && mode_code inside {st_sleep,
         st_lpsleep, st_stop0, st_stop1, st_stop2, st_standby, st_shutdown})
         |-> $past(cpu_wait))
      else $error("entry without wait");
   wake_pulse_a:
      assert property (cpu_wake |=> !cpu_wake)
      else $error("wake pulse too long");
   cover property (mode_code == st_standby);
   cover property (mode_code == st_stop2);
   cover property (cpu_wake);
endmodule // lpm_checker
bind low_power_mode_controller lpm_checker i_chk (
   .core_clk(core_clk), .rstn(rstn), .hsi_request(hsi_request),
   .cpu_wait(cpu_wait), .internal_reset(internal_reset),
   .main_supply_ok(main_supply_ok), .power_ctl(power_ctl),
   .hsi_grant(hsi_grant), .cpu_wake(cpu_wake), .io_analog(io_analog),
   .io_schmitt_en(io_schmitt_en), .reset_pin_pullup_en(reset_pin_pullup_en),
   .battery_select(battery_select), .mode_code(mode_code));
`default_nettype wire

//--- core_periph_model.sv
// Purpose: processor core and wakeup peripheral stand-in
// Assumes: commands from the bench, one cycle long
// Notes: interrupt is held until the core is woken
`timescale 1ns/10ps
`default_nettype none
module core_periph_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic wfi_cmd,
   input wire logic event_cmd,
   input wire logic [3:0] hsi_cmd,
   input wire logic cpu_wake,
   output logic cpu_wait,
   output logic periph_irq,
   output logic [3:0] hsi_request
);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_wait <= 1'b0;
      end else if (cpu_wake) begin
         cpu_wait <= 1'b0;
      end else if (wfi_cmd) begin
         cpu_wait <= 1'b1;
      end
   end
   // a real peripheral keeps its request up until serviced
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         periph_irq <= 1'b0;
      end else if (cpu_wake) begin
         periph_irq <= 1'b0;
      end else if (event_cmd) begin
         periph_irq <= 1'b1;
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hsi_request <= 4'h0;
      end else begin
         hsi_request <= hsi_cmd;
      end
   end
endmodule // core_periph_model
`default_nettype wire

//--- tb_low_power_mode_controller.sv
// Purpose: directed tests of the power mode controller
// Assumes: zero wait apb slave, 100 mhz clock
// Notes: tied: external reset pin, watchdog, crystal fail
`timescale 1ns/10ps
`default_nettype none
module tb_low_power_mode_controller;
   import lpm_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   apb_req_type apb_req = '0;
   apb_rsp_type apb_rsp;
   power_ctl_type power_ctl;
   logic cpu_wait, periph_irq, cpu_wake, wfi_cmd = 1'b0, event_cmd = 1'b0;
   logic [3:0] hsi_request, hsi_grant, mode_code, hsi_cmd = 4'h0;
   logic [4:0] wakeup_pin = 5'h10;
   logic rtc_event = 1'b0, internal_reset = 1'b0, main_supply_ok = 1'b1;
   logic [1:0] sys_clk_sel;
   logic [15:0] io_pull_up, io_pull_dn;
   logic low_speed_osc_en, io_analog, io_schmitt_en, reset_pin_pullup_en;
   logic battery_select, rd_err;
   logic [31:0] rd_data;
   int failures = 0;
   int total_checks = 0;
   always #5 core_clk = ~core_clk;
   low_power_mode_controller i_dut (.core_clk(core_clk), .rstn(rstn),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .cpu_wait(cpu_wait),
      .periph_irq(periph_irq), .hsi_request(hsi_request),
      .external_reset_pin(1'b0), .independent_watchdog(1'b0),
      .wakeup_pin(wakeup_pin), .rtc_event(rtc_event),
      .low_speed_crystal_fail(1'b0), .internal_reset(internal_reset),
      .main_supply_ok(main_supply_ok), .power_ctl(power_ctl),
      .sys_clk_sel(sys_clk_sel), .hsi_grant(hsi_grant),
      .low_speed_osc_en(low_speed_osc_en), .cpu_wake(cpu_wake),
      .io_pull_up(io_pull_up), .io_pull_dn(io_pull_dn),
      .io_analog(io_analog), .io_schmitt_en(io_schmitt_en),
      .reset_pin_pullup_en(reset_pin_pullup_en),
      .battery_select(battery_select), .mode_code(mode_code));
   core_periph_model i_core (.core_clk(core_clk), .rstn(rstn),
      .wfi_cmd(wfi_cmd), .event_cmd(event_cmd), .hsi_cmd(hsi_cmd),
      .cpu_wake(cpu_wake), .cpu_wait(cpu_wait), .periph_irq(periph_irq),
      .hsi_request(hsi_request));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // request held until pready is seen at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      apb_req <= '{paddr: {24'h0, a}, psel: 1'b1, penable: 1'b0,
                   pwrite: wr, pwdata: d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      rd_data = apb_rsp.prdata;
      rd_err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      if (n >= 20) failures++;
   endtask
   task pulse_wfi;
      @(posedge core_clk);
      wfi_cmd <= 1'b1;
      @(posedge core_clk);
      wfi_cmd <= 1'b0;
   endtask
   task pulse_event;
      @(posedge core_clk);
      event_cmd <= 1'b1;
      @(posedge core_clk);
      event_cmd <= 1'b0;
   endtask
   task wait_mode(input logic [3:0] m);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (mode_code !== m && n < 40);
      chk({28'h0, mode_code}, {28'h0, m});
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      @(negedge core_clk);
      chk({28'h0, mode_code}, 32'(st_run));
      chk({30'h0, io_analog, io_schmitt_en}, 32'h2);
      apb(1'b0, ctrl_off, 32'h0);
      chk(rd_data, ctrl_rst);
      $display("test reset finished");
      apb(1'b1, ctrl_off, 32'(sel_sleep));
      repeat (3) @(negedge core_clk);
      chk({28'h0, mode_code}, 32'(st_run));
      pulse_wfi;
      wait_mode(st_sleep);
      pulse_event;
      wait_mode(st_run);
      apb(1'b1, ctrl_off, 32'(sel_lprun));
      wait_mode(st_lprun);
      apb(1'b1, ctrl_off, 32'(sel_sleep));
      pulse_wfi;
      wait_mode(st_lpsleep);
      pulse_event;
      wait_mode(st_lprun);
      apb(1'b1, ctrl_off, 32'(sel_run));
      wait_mode(st_run);
      $display("test sleep finished");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ctrl_off, 32'(sel_stop0) + 32'(i) + (i == 1 ? 32'h10 : 0));
         pulse_wfi;
         wait_mode(4'(st_stop0) + 4'(i));
         @(posedge core_clk);
         hsi_cmd <= 4'h6;
         repeat (3) @(negedge core_clk);
         chk({28'h0, hsi_grant}, 32'h6);
         chk({31'h0, low_speed_osc_en}, 32'h1);
         @(posedge core_clk);
         hsi_cmd <= 4'h0;
         repeat (3) @(negedge core_clk);
         chk({28'h0, hsi_grant}, 32'h0);
         pulse_event;
         wait_mode(st_run);
         chk({30'h0, sys_clk_sel}, i == 1 ? 32'(clk_hsi) : 32'(clk_msi));
      end
      $display("test stop finished");
      apb(1'b1, power_control_reg_three_off, 32'h0000_0423);
      apb(1'b1, io_pull_up_off, 32'h0000_00f0);
      apb(1'b1, io_pull_dn_off, 32'h0000_000f);
      apb(1'b1, ctrl_off, 32'(sel_standby));
      pulse_wfi;
      wait_mode(st_standby);
      chk({31'h0, power_ctl.retain_sram}, 32'h1);
      chk({16'h0, io_pull_up}, 32'h00f0);
      @(posedge core_clk);
      wakeup_pin <= 5'h12;
      pulse_event;
      repeat (4) @(negedge core_clk);
      chk({28'h0, mode_code}, 32'(st_standby));
      @(posedge core_clk);
      wakeup_pin <= 5'h13;
      wait_mode(st_run);
      chk({30'h0, sys_clk_sel}, 32'(clk_msi_low));
      apb(1'b1, ctrl_off, 32'(sel_shutdown));
      pulse_wfi;
      wait_mode(st_shutdown);
      chk({16'h0, io_pull_dn}, 32'h000f);
      @(posedge core_clk);
      wakeup_pin <= 5'h03;
      wait_mode(st_run);
      apb(1'b0, io_pull_up_off, 32'h0);
      chk(rd_data, 32'h0);
      apb(1'b0, wake_off, 32'h0);
      chk(rd_data, 32'h0000_0011);
      apb(1'b1, wake_off, 32'h0000_0011);
      apb(1'b0, wake_off, 32'h0);
      chk(rd_data, 32'h0);
      $display("test deep modes finished");
      apb(1'b1, ctrl_off, 32'h0000_0060);
      repeat (2) @(negedge core_clk);
      chk({30'h0, power_ctl.flash_pd, power_ctl.sram_clk_en}, 32'h2);
      apb(1'b0, 8'h20, 32'h0);
      chk({rd_data[30:0], rd_err}, 32'h1);
      @(posedge core_clk);
      main_supply_ok <= 1'b0;
      rtc_event <= 1'b1;
      internal_reset <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk({31'h0, battery_select}, 32'h1);
      chk({31'h0, reset_pin_pullup_en}, 32'h0);
      apb(1'b0, status_off, 32'h0);
      chk(rd_data, 32'h0000_0010);
      $display("test supply finished");
      final_report;
   end
   initial begin
      #50000;
      failures++;
      final_report;
   end
endmodule // tb_low_power_mode_controller
`default_nettype wire
